// File: verilog/smac_defines.vh
`ifndef SMAC_DEFINES_VH
`define SMAC_DEFINES_VH

// security byte field positions
`define SMAC_STATE_LSB        0
`define SMAC_STATE_MSB        1
`define SMAC_BKEN_LSB         6
`define SMAC_BKEN_MSB         7
// two-bit codes
`define SMAC_STATE_UNSECURED  2'h2
`define SMAC_BKEN_ENABLED     2'h2
// reset value of the latched security byte (secured, key disabled)
`define SMAC_SECREG_RESET     8'h01
// key words that can never form a valid key
`define SMAC_KEY_ZERO         16'h0000
`define SMAC_KEY_ONES         16'hFFFF
// option sector and key area addresses
`define SMAC_OPT_ADDR         16'hFF0F
`define SMAC_KEY_BASE         16'hFF00
`define SMAC_KEY_LAST         16'hFF07
`define SMAC_SECTOR_BASE      16'hFE00
`define SMAC_SECTOR_LAST      16'hFFFF
// peripheral register window for restricted debug access
`define SMAC_REG_BASE         16'h0000
`define SMAC_REG_LAST         16'h07FF
// operating mode encodings
`define SMAC_MODE_NORM        2'h0
`define SMAC_MODE_SS          2'h1
`define SMAC_MODE_NX          2'h2
`define SMAC_MODE_OTHER       2'h3
// nvm command classes
`define SMAC_NVM_ERASE_SECT   2'h1
`define SMAC_NVM_PROGRAM      2'h2
`define SMAC_NVM_MASS_ERASE   2'h3

`endif

// File: verilog/smac_key_check.v
`timescale 1ns/1ps
// compares a presented 64-bit key against the stored key
module smac_key_check (
    // clock and reset
    input  wire        sys_clk,
    input  wire        sys_rst,
    // key request
    input  wire        start,
    input  wire [63:0] key_given,
    input  wire [63:0] key_stored,
    // result
    output reg         done,
    output reg         match
);
`include "smac_defines.vh"

// a key word of all zeros or all ones is never valid
function word_ok;
    input [15:0] w;
    begin
        word_ok = (w != `SMAC_KEY_ZERO) && (w != `SMAC_KEY_ONES);
    end
endfunction

function key_ok;
    input [63:0] k;
    begin
        key_ok = word_ok(k[15:0]) && word_ok(k[31:16]) &&
                 word_ok(k[47:32]) && word_ok(k[63:48]);
    end
endfunction

//------------------------------------------------------------
// comparison, result registered one cycle after start
//------------------------------------------------------------
always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        done  <= 1'b0;
        match <= 1'b0;
    end else begin
        done  <= start;
        match <= start && key_ok(key_given) && key_ok(key_stored) &&
                 (key_given == key_stored);               // [R09]
    end
end

endmodule // smac_key_check

// File: verilog/smac_blank_check.v
`timescale 1ns/1ps
// walks program and data memory, requesting a blank test per location
module smac_blank_check (
    // clock and reset
    input  wire        sys_clk,
    input  wire        sys_rst,
    // control
    input  wire        start,
    // memory probe port
    output reg  [15:0] probe_addr,
    output reg         probe_data_mem,
    output wire        probe_req,
    input  wire        probe_ack,
    input  wire        probe_erased,
    input  wire        probe_last,
    // result
    output wire        busy,
    output reg         done,
    output reg         blank
);

localparam ST_IDLE = 2'h0;
localparam ST_PROG = 2'h1;
localparam ST_DATA = 2'h2;

reg [1:0] state;
reg [1:0] next_state;
reg       all_blank;
wire [16:0] addr_inc = {1'b0, probe_addr} + 17'h00001;

assign busy      = (state != ST_IDLE);
assign probe_req = busy;

// program memory first, then data memory
always @* begin
    next_state = state;
    case (state)
        ST_IDLE: if (start) next_state = ST_PROG;
        ST_PROG: if (probe_ack && probe_last) next_state = ST_DATA;
        ST_DATA: if (probe_ack && probe_last) next_state = ST_IDLE;
        default: next_state = ST_IDLE;
    endcase
end

//------------------------------------------------------------
// walk and accumulate
//------------------------------------------------------------
always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        state          <= ST_IDLE;
        probe_addr     <= 16'h0000;
        probe_data_mem <= 1'b0;
        all_blank      <= 1'b1;
        done           <= 1'b0;
        blank          <= 1'b0;
    end else begin
        state <= next_state;
        done  <= 1'b0;
        if (state == ST_IDLE && start) begin
            probe_addr     <= 16'h0000;
            probe_data_mem <= 1'b0;
            all_blank      <= 1'b1;
        end else if (busy && probe_ack) begin
            all_blank  <= all_blank & probe_erased;     // [R05]
            probe_addr <= probe_last ? 16'h0000 : addr_inc[15:0];
            if (probe_last) probe_data_mem <= 1'b1;
            if (state == ST_DATA && probe_last) begin
                done  <= 1'b1;
                blank <= all_blank & probe_erased;      // [R06]
            end
        end
    end
end

endmodule // smac_blank_check

// File: verilog/smac_access_ctrl.v
`timescale 1ns/1ps
// How it works
// R01 - secured normal mode rejects all debug commands
// R02 - secured single chip: no trace, restricted nvm
// R03 - failed blank check: hardware commands, registers only
// R04 - special mode debug port active from reset
// R05 - secured special reset runs blank check, blank unsecures
// R06 - nonblank: stay secured, registers reachable for erase
// R07 - debug port fully blocked during blank check
// R08 - normal modes unsecure via enabled valid backdoor key
// R09 - all-zero or all-ones key words never valid
// R10 - erasing option byte erases its whole sector
// R11 - protected option sector refuses erase and program
// R12 - reprogrammed security takes effect only at reset
// R13 - host avoids erase-reprogram unsecure in normal mode
// R14 - host mass erases both memories then resets
// R15 - blank special reset enables all debug commands
// R16 - only security code 10 means unsecured
// R17 - backdoor enable only when field is 10
// R18 - every reset copies option byte into security register
// R19 - backdoor unsecure lasts until next reset
module smac_access_ctrl (
    // clock and reset
    input  wire        sys_clk,
    input  wire        sys_rst,
    // mode straps and option byte from nonvolatile memory
    input  wire [1:0]  mode_sel,
    input  wire [7:0]  option_byte,
    input  wire [63:0] key_stored,
    input  wire        sector_protected,
    // background debug command request
    input  wire        dbg_req,
    input  wire        dbg_is_firmware,
    input  wire [15:0] dbg_addr,
    output wire        dbg_grant,
    output wire        dbg_reject,
    // backdoor key presentation
    input  wire        key_present,
    input  wire [63:0] key_given,
    // nvm command request
    input  wire        nvm_req,
    input  wire [1:0]  nvm_cmd,
    input  wire [15:0] nvm_addr,
    input  wire        nvm_cmd_unrestricted,
    output wire        nvm_grant,
    output wire        nvm_reject,
    output reg         nvm_sector_erase_all,
    // memory probe port for the blank check
    output wire [15:0] probe_addr,
    output wire        probe_data_mem,
    output wire        probe_req,
    input  wire        probe_ack,
    input  wire        probe_erased,
    input  wire        probe_last,
    // status
    output reg  [7:0]  flash_security_register,
    output wire        secured,
    output reg         background_debug_port_active,
    output wire        trace_debug_unit_enable,
    output wire        blank_check_busy,
    output reg         backdoor_unlocked
);
`include "smac_defines.vh"

//------------------------------------------------------------
// local state
//------------------------------------------------------------
reg         rst_done;
reg         check_started;
reg         blank_unlocked;
reg         blank_failed;
reg  [1:0]  mode;
wire        bc_done;
wire        bc_blank;
wire        key_done;
wire        key_match;
wire [1:0]  security_state_field;
wire [1:0]  backdoor_enable_field;
wire        base_secured;
wire        normal_single_chip_mode;
wire        special_mode;
wire        start_check;

// address window test used by both request groups
function in_range;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
        in_range = (a >= lo) && (a <= hi);
    end
endfunction

assign security_state_field  =
    flash_security_register[`SMAC_STATE_MSB:`SMAC_STATE_LSB];
assign backdoor_enable_field =
    flash_security_register[`SMAC_BKEN_MSB:`SMAC_BKEN_LSB];
assign base_secured = (security_state_field != `SMAC_STATE_UNSECURED); // [R16]
assign normal_single_chip_mode = (mode == `SMAC_MODE_NORM);
assign special_mode = (mode == `SMAC_MODE_SS);

// either unlock path lifts security until the next reset
assign secured = base_secured && !backdoor_unlocked
                 && !blank_unlocked;                      // [R19]

assign start_check = rst_done && !check_started && special_mode
                     && base_secured;                     // [R05]

//------------------------------------------------------------
// reset sequence: latch straps and security byte once
//------------------------------------------------------------
// straps are caught by the first clocked edge after release
always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        rst_done                <= 1'b0;
        mode                    <= `SMAC_MODE_NORM;
        flash_security_register <= `SMAC_SECREG_RESET;
    end else if (!rst_done) begin
        rst_done                <= 1'b1;
        mode                    <= mode_sel;
        flash_security_register <= option_byte;           // [R18] [R12]
    end
end

// debug port wakes active in special mode, as soon as modes latch
always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        background_debug_port_active <= 1'b0;
    end else begin
        background_debug_port_active <= rst_done ? special_mode
                                       : (mode_sel == `SMAC_MODE_SS); // [R04]
    end
end

//------------------------------------------------------------
// blank check outcome
//------------------------------------------------------------
always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        check_started  <= 1'b0;
        blank_unlocked <= 1'b0;
        blank_failed   <= 1'b0;
    end else begin
        if (start_check) check_started <= 1'b1;
        if (bc_done) begin
            blank_unlocked <= bc_blank;                   // [R05] [R15]
            blank_failed   <= !bc_blank;                  // [R06]
        end
    end
end

smac_blank_check u_blank (
    .sys_clk        (sys_clk),
    .sys_rst        (sys_rst),
    .start          (start_check),
    .probe_addr     (probe_addr),
    .probe_data_mem (probe_data_mem),
    .probe_req      (probe_req),
    .probe_ack      (probe_ack),
    .probe_erased   (probe_erased),
    .probe_last     (probe_last),
    .busy           (blank_check_busy),
    .done           (bc_done),
    .blank          (bc_blank)
);

//------------------------------------------------------------
// backdoor key: normal modes only, enable field must be 10
//------------------------------------------------------------
smac_key_check u_key (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .start      (key_present && rst_done),
    .key_given  (key_given),
    .key_stored (key_stored),
    .done       (key_done),
    .match      (key_match)
);

// sticky until reset; a failed try never relocks a granted unlock
always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        backdoor_unlocked <= 1'b0;
    end else if (key_done && key_match && !special_mode
                 && backdoor_enable_field == `SMAC_BKEN_ENABLED) begin
        backdoor_unlocked <= 1'b1;                        // [R08] [R17]
    end
end

//------------------------------------------------------------
// debug command gating
//------------------------------------------------------------
reg dbg_ok;
always @* begin
    dbg_ok = 1'b0;
    if (!rst_done || blank_check_busy) begin
        dbg_ok = 1'b0;                                    // [R07]
    // still blocked in the done cycle, until the result is latched
    end else if (special_mode && check_started
                 && !blank_unlocked && !blank_failed) begin
        dbg_ok = 1'b0;                                    // [R07]
    end else if (!secured) begin
        dbg_ok = 1'b1;                                    // [R15]
    end else if (normal_single_chip_mode) begin
        dbg_ok = 1'b0;                                    // [R01]
    end else if (special_mode) begin
        // firmware off, hardware limited to register window
        dbg_ok = !dbg_is_firmware &&
                 in_range(dbg_addr, `SMAC_REG_BASE,
                          `SMAC_REG_LAST);                // [R03] [R06]
    end else begin
        dbg_ok = 1'b1;
    end
end

assign dbg_grant  = dbg_req && dbg_ok;
assign dbg_reject = dbg_req && !dbg_ok;

// trace capture blocked until the reset sequence is done, and while secured in single chip modes
assign trace_debug_unit_enable = rst_done &&
    !(secured && (normal_single_chip_mode || special_mode)); // [R02]

//------------------------------------------------------------
// nvm command gating
//------------------------------------------------------------
reg nvm_ok;
reg opt_hit;
always @* begin
    nvm_ok  = 1'b1;
    opt_hit = in_range(nvm_addr, `SMAC_SECTOR_BASE, `SMAC_SECTOR_LAST);
    if (!rst_done) begin
        nvm_ok = 1'b0;
    end else if (secured && (normal_single_chip_mode || special_mode)
                 && !nvm_cmd_unrestricted) begin
        nvm_ok = 1'b0;                                    // [R02]
    end else if (opt_hit && sector_protected &&
                 (nvm_cmd == `SMAC_NVM_ERASE_SECT ||
                  nvm_cmd == `SMAC_NVM_PROGRAM)) begin
        nvm_ok = 1'b0;                                    // [R11]
    end
end

assign nvm_grant  = nvm_req && nvm_ok;
assign nvm_reject = nvm_req && !nvm_ok;

// erase of the option byte widens to the whole sector
always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
        nvm_sector_erase_all <= 1'b0;
    end else begin
        nvm_sector_erase_all <= nvm_grant && opt_hit &&
                                nvm_cmd == `SMAC_NVM_ERASE_SECT; // [R10]
    end
end

endmodule // smac_access_ctrl

// File: tb/smac_access_ctrl_props.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the access control
// ----------------------------------------
module smac_props (
    input wire        sys_clk,
    input wire        sys_rst,
    input wire [1:0]  mode_sel,
    input wire [7:0]  option_byte,
    input wire        sector_protected,
    input wire        dbg_req,
    input wire        dbg_is_firmware,
    input wire [15:0] dbg_addr,
    input wire        dbg_reject,
    input wire        key_present,
    input wire        nvm_req,
    input wire [1:0]  nvm_cmd,
    input wire [15:0] nvm_addr,
    input wire        nvm_grant,
    input wire        nvm_reject,
    input wire        nvm_sector_erase_all,
    input wire        probe_ack,
    input wire        probe_data_mem,
    input wire        probe_last,
    input wire [7:0]  flash_security_register,
    input wire        secured,
    input wire        background_debug_port_active,
    input wire        trace_debug_unit_enable,
    input wire        blank_check_busy,
    input wire        backdoor_unlocked
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // debug gating
    chk_normal_debug_off: assert property (
        secured && mode_sel == 2'h0 && dbg_req |-> dbg_reject)
        else $error("debug allowed, secured normal mode");
    chk_busy_blocks: assert property (
        blank_check_busy && dbg_req |-> dbg_reject)
        else $error("debug allowed during blank check");
    chk_ss_no_fw: assert property (
        secured && mode_sel == 2'h1 && dbg_req && dbg_is_firmware
        |-> dbg_reject) else $error("firmware command allowed");
    chk_ss_reg_only: assert property (
        secured && mode_sel == 2'h1 && dbg_req && dbg_addr > 16'h07FF
        |-> dbg_reject) else $error("access outside register area");
    chk_trace_off: assert property (
        secured && !mode_sel[1] |-> !trace_debug_unit_enable)
        else $error("trace enabled while secured");
    // security state
    chk_code_unsec: assert property (
        flash_security_register[1:0] == 2'h2 |-> !secured)
        else $error("unsecured code but secured");
    chk_opt_copy: assert property (
        $fell(sys_rst) |=> flash_security_register == $past(option_byte))
        else $error("option byte not copied");
    chk_sec_hold: assert property (
        !$past(sys_rst) && !$past(sys_rst, 2)
        |-> $stable(flash_security_register))
        else $error("security register changed without reset");
    chk_ss_bdp_on: assert property (
        $fell(sys_rst) && mode_sel == 2'h1
        |=> background_debug_port_active)
        else $error("debug port not active in special mode");
    chk_blank_end: assert property (
        $fell(blank_check_busy)
        |-> $past(probe_ack && probe_data_mem && probe_last))
        else $error("blank check ended early");
    chk_key_cause: assert property (
        $rose(backdoor_unlocked) |-> $past(key_present, 2)
        && option_byte[7:6] == 2'h2 && mode_sel != 2'h1)
        else $error("unlock without enabled key");
    // option sector
    chk_sect_erase: assert property (
        nvm_grant && nvm_cmd == 2'h1 && nvm_addr >= 16'hFE00
        |=> nvm_sector_erase_all) else $error("sector erase missing");
    chk_prot_refuse: assert property (
        nvm_req && sector_protected && nvm_addr >= 16'hFE00
        && (nvm_cmd == 2'h1 || nvm_cmd == 2'h2) |-> nvm_reject)
        else $error("protected sector not refused");
    // main scenarios
    cov_blank: cover property ($fell(blank_check_busy));
    cov_unlock: cover property ($rose(backdoor_unlocked));
    cov_erase: cover property (nvm_sector_erase_all);
endmodule // smac_props

bind smac_access_ctrl smac_props u_props (
    .sys_clk, .sys_rst, .mode_sel, .option_byte, .sector_protected,
    .dbg_req, .dbg_is_firmware, .dbg_addr, .dbg_reject, .key_present,
    .nvm_req, .nvm_cmd, .nvm_addr, .nvm_grant, .nvm_reject,
    .nvm_sector_erase_all, .probe_ack, .probe_data_mem, .probe_last,
    .flash_security_register, .secured, .background_debug_port_active,
    .trace_debug_unit_enable, .blank_check_busy, .backdoor_unlocked
);

// File: tb/smac_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// memory answering blank check probes
// ----------------------------------------
module smac_mem_model (
    input  wire        sys_clk,
    input  wire        sys_rst,
    input  wire        slow,
    input  wire        dirty,
    input  wire        probe_req,
    input  wire [15:0] probe_addr,
    input  wire        probe_data_mem,
    output reg         probe_ack,
    output wire        probe_erased,
    output wire        probe_last
);
    reg [1:0] wait_cnt;
    // slow mode stretches each answer to three cycles
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            probe_ack <= 1'b0;
            wait_cnt  <= 2'h0;
        end else if (probe_req && !probe_ack
                     && wait_cnt >= {slow, 1'b0}) begin
            probe_ack <= 1'b1;
            wait_cnt  <= 2'h0;
        end else begin
            probe_ack <= 1'b0;
            wait_cnt  <= probe_req ? wait_cnt + 2'h1 : 2'h0;
        end
    end
    // four words per memory; outside an answer the lines toggle
    assign probe_erased = probe_ack ? !(dirty && probe_data_mem
                          && probe_addr == 16'h0002) : wait_cnt[0];
    assign probe_last = probe_ack ? probe_addr == 16'h0003 : !wait_cnt[0];
endmodule // smac_mem_model

// File: tb/smac_access_ctrl_bench.sv
`timescale 1ns/1ps
module smac_access_ctrl_bench;
    reg         sys_clk, sys_rst, slow, dirty, sector_protected;
    reg  [1:0]  mode_sel, nvm_cmd;
    reg  [7:0]  option_byte;
    reg  [63:0] key_stored, key_given;
    reg         dbg_req, dbg_is_firmware, key_present;
    reg         nvm_req, nvm_cmd_unrestricted;
    reg  [15:0] dbg_addr, nvm_addr;
    wire [15:0] probe_addr;
    wire        probe_data_mem, probe_req, probe_ack, probe_erased;
    wire        probe_last, dbg_grant, dbg_reject, nvm_grant, nvm_reject;
    wire        secured, bdp_act, trace_en, busy, unlocked;
    wire [7:0]  fsr;
    integer     num_errors, n_compared, cycles, i, n;
    reg  [31:0] exp_q[$];
    reg  [31:0] e;
    wire [15:0] obs = {fsr, dbg_grant, dbg_reject, nvm_grant, nvm_reject,
                       secured, unlocked, trace_en, bdp_act};

    smac_access_ctrl dut_u (
        .sys_clk, .sys_rst, .mode_sel, .option_byte, .key_stored,
        .sector_protected, .dbg_req, .dbg_is_firmware, .dbg_addr,
        .dbg_grant, .dbg_reject, .key_present, .key_given, .nvm_req,
        .nvm_cmd, .nvm_addr, .nvm_cmd_unrestricted, .nvm_grant,
        .nvm_reject, .nvm_sector_erase_all(), .probe_addr,
        .probe_data_mem, .probe_req, .probe_ack, .probe_erased,
        .probe_last, .flash_security_register(fsr), .secured,
        .background_debug_port_active(bdp_act),
        .trace_debug_unit_enable(trace_en), .blank_check_busy(busy),
        .backdoor_unlocked(unlocked));
    smac_mem_model mem_u (
        .sys_clk, .sys_rst, .slow, .dirty, .probe_req, .probe_addr,
        .probe_data_mem, .probe_ack, .probe_erased, .probe_last);

    // ----------------------------------------
    // clock, watchdog and result monitor
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // a hang ends the run instead of stalling it
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            finish_test;
        end
    end
    // oldest note: mask over expected, against masked outputs
    always @(posedge sys_clk) begin
        if (exp_q.size() != 0) begin
            e = exp_q.pop_front();
            n_compared = n_compared + 1;
            if ((obs & e[31:16]) !== e[15:0]) begin
                num_errors = num_errors + 1;
                $display("MISMATCH t=%0t exp=%h got=%h", $time,
                         e[15:0], obs & e[31:16]);
            end
        end
    end

    // ----------------------------------------
    // drivers, all changing at the falling edge
    // ----------------------------------------
    task expect_now(input [15:0] m, input [15:0] v);
        begin
            exp_q.push_back({m, v});
            @(negedge sys_clk);
        end
    endtask
    task do_reset(input [1:0] m, input [7:0] o);
        begin
            sys_rst = 1'b1;
            mode_sel = m;
            option_byte = o;
            repeat (5) @(negedge sys_clk);
            sys_rst = 1'b0;
            repeat (2) @(negedge sys_clk);
        end
    endtask
    task dbg(input fw, input [15:0] a, input [1:0] ex);
        begin
            dbg_req = 1'b1;
            dbg_is_firmware = fw;
            dbg_addr = a;
            expect_now(16'h00C0, {8'h00, ex, 6'h00});
            dbg_req = 1'b0;
            @(negedge sys_clk);
        end
    endtask
    task nvm(input [1:0] c, input [15:0] a, input u, input [1:0] ex);
        begin
            nvm_req = 1'b1;
            nvm_cmd = c;
            nvm_addr = a;
            nvm_cmd_unrestricted = u;
            expect_now(16'h0030, {10'h000, ex, 4'h0});
            nvm_req = 1'b0;
            @(negedge sys_clk);
        end
    endtask
    // key words never all zeros or all ones
    task new_key;
        for (n = 0; n < 4; n = n + 1)
            key_stored[n*16 +: 16] = $urandom_range(16'hFFFE, 16'h0001);
    endtask
    task send_key;
        begin
            key_given = key_stored;
            key_present = 1'b1;
            @(negedge sys_clk);
            key_present = 1'b0;
            repeat (2) @(negedge sys_clk);
        end
    endtask
    // result latches one cycle after busy drops
    task wait_blank;
        begin
            for (n = 0; n < 200 && busy !== 1'b0; n = n + 1)
                @(negedge sys_clk);
            if (busy !== 1'b0) begin
                num_errors = num_errors + 1;
                finish_test;
            end else
                @(negedge sys_clk);
        end
    endtask
    task finish_test;
        begin
            $display("compared %0d mismatches %0d", n_compared, num_errors);
            if (num_errors == 0 && n_compared > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {sys_rst, slow, dirty, sector_protected} = 4'h8;
        {dbg_req, dbg_is_firmware, key_present, nvm_req} = 4'h0;
        {mode_sel, nvm_cmd, option_byte, nvm_cmd_unrestricted} = 13'h0;
        {dbg_addr, nvm_addr, key_given, key_stored} = 160'h0;
        {num_errors, n_compared, cycles} = 96'h0;
        n = $urandom(20386);
        // every security code in normal single chip
        for (i = 0; i < 4; i = i + 1) begin
            do_reset(2'h0, i[7:0]);
            expect_now(16'hFF08, {i[7:0], 4'h0, i != 2, 3'h0});
            dbg(1'b0, 16'h0000, (i == 2) ? 2'h2 : 2'h1);
        end
        expect_now(16'h0002, 16'h0000);
        nvm(2'h2, 16'h1000, 1'b0, 2'h1);
        nvm(2'h2, 16'h1000, 1'b1, 2'h2);
        $display("test 1 done");
        // every key enable code, then unusable key words
        for (i = 0; i < 4; i = i + 1) begin
            new_key;
            do_reset(2'h0, {i[1:0], 6'h01});
            send_key;
            expect_now(16'h000C, {12'h000, i != 2, i == 2, 2'h0});
        end
        for (i = 0; i < 2; i = i + 1) begin
            new_key;
            key_stored[$urandom_range(3, 0) * 16 +: 16] = {16{i[0]}};
            do_reset(2'h0, 8'h81);
            send_key;
            expect_now(16'h000C, 16'h0008);
        end
        new_key;
        send_key;
        expect_now(16'h000C, 16'h0004);
        do_reset(2'h0, 8'h81);
        expect_now(16'h000C, 16'h0008);
        $display("test 2 done");
        // option sector erase and protection
        do_reset(2'h0, 8'h02);
        nvm(2'h1, 16'hFE40, 1'b1, 2'h2);
        sector_protected = 1'b1;
        nvm(2'h1, 16'hFE40, 1'b1, 2'h1);
        nvm(2'h2, 16'hFF0F, 1'b1, 2'h1);
        sector_protected = 1'b0;
        $display("test 3 done");
        // special mode, blank memory behind a slow responder
        slow = 1'b1;
        do_reset(2'h1, 8'h01);
        expect_now(16'h0001, 16'h0001);
        dbg(1'b0, 16'h0010, 2'h1);
        wait_blank;
        expect_now(16'h0008, 16'h0000);
        dbg(1'b1, 16'h4000, 2'h2);
        $display("test 4 done");
        // special mode, one dirty word, erase and reprogram
        slow = 1'b0;
        dirty = 1'b1;
        do_reset(2'h1, 8'h01);
        wait_blank;
        expect_now(16'hFF0A, 16'h0108);
        dbg(1'b1, 16'h0010, 2'h1);
        dbg(1'b0, 16'h0010, 2'h2);
        dbg(1'b0, 16'h0800, 2'h1);
        nvm(2'h3, 16'h0000, 1'b1, 2'h2);
        dirty = 1'b0;
        do_reset(2'h1, 8'h01);
        wait_blank;
        nvm(2'h2, 16'hFF0F, 1'b1, 2'h2);
        expect_now(16'hFF08, 16'h0100);
        do_reset(2'h0, 8'h02);
        expect_now(16'hFF08, 16'h0200);
        $display("test 5 done");
        finish_test;
    end
endmodule // smac_access_ctrl_bench
